// ===== src/dssh_core.sv
// Dual spindle speed/phase synchronisation handshake
// Contract
// (R1) Sync mode is entered while the mode request is 1 and left when it returns to 0.
// (R2) The phase-sync request is ignored unless the mode request is asserted.
// (R3) The sequencer raises phase-sync only after speed-sync-done was reported.
// (R4) A phase alignment starts on each rising edge of the phase-sync request; the core ignores a rise during an alignment or in the first cycle of mode.
// (R5) Phase relation is kept when the request falls; the next rise realigns.
// (R6) An integral-disable bit of 1 suppresses that spindle's integral action.
// (R7) The sequencer sets both integral-disable bits while spindles share a workpiece.
// (R8) Speed-sync-done rises in mode when both spindles are at speed within tolerance.
// (R9) Speed-sync-done clears when not at speed, out of tolerance, or mode off.
// (R10) Phase-sync-done rises when at speed, aligned, and error within phase tolerance.
// (R11) Phase-sync-done clears when not aligned, out of tolerance, or mode off.
// (R12) After sync took effect, the alarm rises when error exceeds the alarm threshold.
// (R13) The alarm is 0 with mode off or error at or below the threshold.
// (R14) Raising phase-sync drops speed-sync-done until alignment completes.
// (R15) The sequencer keeps rotation direction fixed while sync mode is active.
// (R16) Reset clears all three flags and treats both requests as deasserted.
`include "dssh_regs.svh"
`timescale 1ns/10ps
module dssh_core #(
    parameter int SPEED_W   = `DSSH_SPEED_W,
    parameter int ERR_W     = `DSSH_ERR_W,
    parameter int PHASE_CYC = `DSSH_PHASE_CYC
) (
    // Clock and reset
    input  wire logic               CLK,
    input  wire logic               RESET,
    // Sequencer request pins
    input  wire logic               SYNC_MODE_REQUEST,
    input  wire logic               PHASE_SYNC_REQUEST,
    input  wire logic               INTEGRAL_DISABLE_FIRST,
    input  wire logic               INTEGRAL_DISABLE_SECOND,
    input  wire logic               FORWARD_ROTATE_CMD,
    // Spindle measurements, same clock domain
    input  wire logic [SPEED_W-1:0] SPEED_CMD,
    input  wire logic [SPEED_W-1:0] SPEED_FIRST,
    input  wire logic [SPEED_W-1:0] SPEED_SECOND,
    input  wire logic [ERR_W-1:0]   ERR_PULSE_DIFF,
    // Thresholds
    input  wire logic [SPEED_W-1:0] SPEED_TOL,
    input  wire logic [ERR_W-1:0]   PHASE_TOL,
    input  wire logic [ERR_W-1:0]   ALARM_THRESH,
    // Status outputs
    output logic                    SPEED_SYNC_DONE,
    output logic                    PHASE_SYNC_DONE,
    output logic                    SYNC_ERROR_ALARM,
    // Servo control outputs
    output logic                    INTEGRAL_EN_FIRST,
    output logic                    INTEGRAL_EN_SECOND,
    output logic                    ALIGN_ACTIVE,
    output logic                    FORWARD_LATCHED
);
    import dssh_pkg::*;

    if (SPEED_W < 2 || ERR_W < 2) begin : g_bad_width
        $error("dssh_core: widths too small");
    end
    // Alignment counter is sixteen bits wide
    if (PHASE_CYC < 1 || PHASE_CYC > 65535) begin : g_bad_cyc
        $error("dssh_core: PHASE_CYC out of range");
    end

    dssh_sync_if sif ();
    assign sif.raw = {FORWARD_ROTATE_CMD, INTEGRAL_DISABLE_SECOND,
                      INTEGRAL_DISABLE_FIRST, PHASE_SYNC_REQUEST, SYNC_MODE_REQUEST};

    dssh_pin_sync #(.W(5)) u_sync (
        .clk   (CLK),
        .reset (RESET),
        .bus   (sif.sync)
    );

    logic mode_req, phase_req, intg_a, intg_b, fwd;
    assign mode_req  = sif.q[0];
    assign phase_req = sif.q[1];
    assign intg_a    = sif.q[2];
    assign intg_b    = sif.q[3];
    assign fwd       = sif.q[4];

    // Speed comparisons
    logic [SPEED_W-1:0] dev_a, dev_b, diff_ab;
    logic               at_speed, in_speed_tol, in_phase_tol, over_alarm;
    assign dev_a   = (SPEED_FIRST  > SPEED_CMD) ? SPEED_FIRST - SPEED_CMD
                                               : SPEED_CMD - SPEED_FIRST;
    assign dev_b   = (SPEED_SECOND > SPEED_CMD) ? SPEED_SECOND - SPEED_CMD
                                               : SPEED_CMD - SPEED_SECOND;
    assign diff_ab = (SPEED_FIRST > SPEED_SECOND) ? SPEED_FIRST - SPEED_SECOND
                                                  : SPEED_SECOND - SPEED_FIRST;
    // Reaching the command reuses the same tolerance window
    assign at_speed     = (dev_a <= SPEED_TOL) && (dev_b <= SPEED_TOL);
    assign in_speed_tol = diff_ab <= SPEED_TOL;
    assign in_phase_tol = ERR_PULSE_DIFF <= PHASE_TOL;
    assign over_alarm   = ERR_PULSE_DIFF > ALARM_THRESH;

    // Control state
    dssh_state_t        state, next_state;
    logic               phase_prev, next_phase_prev;
    logic [15:0]        align_cnt, next_align_cnt;
    logic               sync_effective, next_sync_effective;
    logic               spd_done, next_spd_done;
    logic               ph_done, next_ph_done;
    logic               alarm, next_alarm;
    logic               int_a, next_int_a;
    logic               int_b, next_int_b;
    logic               fwd_l, next_fwd_l;
    logic               align_q, next_align_q;
    logic               phase_rise;

    // Edge only counts in mode; level is ignored
    assign phase_rise = mode_req && phase_req && !phase_prev; // [R2] [R4]

    always_comb begin
        next_state          = state;
        next_phase_prev     = phase_req;
        next_align_cnt      = align_cnt;
        next_sync_effective = sync_effective;
        unique case (state)
            DSSH_OFF: begin
                next_sync_effective = 1'b0;
                if (mode_req) next_state = DSSH_SPEED; // [R1]
            end
            DSSH_SPEED, DSSH_PHASED: begin
                if (at_speed && in_speed_tol) next_sync_effective = 1'b1;
                if (phase_rise) begin // [R4] [R5]
                    next_state     = DSSH_ALIGN;
                    next_align_cnt = 16'(PHASE_CYC - 1);
                end
            end
            DSSH_ALIGN: begin
                if (align_cnt != 16'h0000) next_align_cnt = align_cnt - 16'h0001;
                else if (in_phase_tol) next_state = DSSH_PHASED;
            end
        endcase
        if (!mode_req) next_state = DSSH_OFF; // [R1]
    end

    always_comb begin
        // Speed-done drops during alignment, returns once phased
        next_spd_done = (state == DSSH_SPEED || state == DSSH_PHASED) && !phase_rise
                        && mode_req && at_speed && in_speed_tol; // [R8] [R9] [R14]
        next_ph_done  = (state == DSSH_PHASED) && mode_req
                        && at_speed && in_phase_tol; // [R10] [R11]
        next_alarm    = mode_req && sync_effective && over_alarm; // [R12] [R13]
        next_int_a    = !intg_a; // [R6]
        next_int_b    = !intg_b; // [R6]
        // Direction frozen while in sync mode; sequencer must not change it
        next_fwd_l    = (state == DSSH_OFF) ? fwd : fwd_l; // [R15]
        // Registered so the pin never shows a state decode glitch
        next_align_q  = (next_state == DSSH_ALIGN); // [R4]
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin // [R16]
            state          <= DSSH_OFF;
            phase_prev     <= 1'b0;
            align_cnt      <= 16'h0000;
            sync_effective <= 1'b0;
            spd_done       <= 1'b0;
            ph_done        <= 1'b0;
            alarm          <= 1'b0;
            int_a          <= 1'b1;
            int_b          <= 1'b1;
            fwd_l          <= 1'b0;
            align_q        <= 1'b0;
        end else begin
            state          <= next_state;
            phase_prev     <= next_phase_prev;
            align_cnt      <= next_align_cnt;
            sync_effective <= next_sync_effective;
            spd_done       <= next_spd_done;
            ph_done        <= next_ph_done;
            alarm          <= next_alarm;
            int_a          <= next_int_a;
            int_b          <= next_int_b;
            fwd_l          <= next_fwd_l;
            align_q        <= next_align_q;
        end
    end

    assign SPEED_SYNC_DONE    = spd_done;
    assign PHASE_SYNC_DONE    = ph_done;
    assign SYNC_ERROR_ALARM   = alarm;
    assign INTEGRAL_EN_FIRST  = int_a;
    assign INTEGRAL_EN_SECOND = int_b;
    assign ALIGN_ACTIVE       = align_q;
    assign FORWARD_LATCHED    = fwd_l;

    // Checks
    property p_mode_exit;
        @(posedge CLK) disable iff (RESET)
        !mode_req |=> state == DSSH_OFF;
    endproperty
    a_mode_exit: assert property (p_mode_exit) else $error("mode not left"); // [R1]

    property p_phase_ignored;
        @(posedge CLK) disable iff (RESET)
        (state == DSSH_SPEED && !mode_req) |=> state != DSSH_ALIGN;
    endproperty
    a_phase_ignored: assert property (p_phase_ignored) else $error("phase taken off mode"); // [R2]

    property p_rise_align;
        @(posedge CLK) disable iff (RESET)
        (state == DSSH_SPEED && phase_rise) |=> state == DSSH_ALIGN;
    endproperty
    a_rise_align: assert property (p_rise_align) else $error("no align on edge"); // [R4]

    property p_level_no_realign;
        @(posedge CLK) disable iff (RESET)
        (state == DSSH_PHASED && phase_prev && phase_req) |=> state != DSSH_ALIGN;
    endproperty
    a_level_no_realign: assert property (p_level_no_realign) else $error("level realigned"); // [R5]

    property p_integral;
        @(posedge CLK) disable iff (RESET)
        intg_a |=> !INTEGRAL_EN_FIRST;
    endproperty
    a_integral: assert property (p_integral) else $error("integral not off"); // [R6]

    property p_speed_clear;
        @(posedge CLK) disable iff (RESET)
        (!mode_req || !at_speed || !in_speed_tol) |=> !SPEED_SYNC_DONE;
    endproperty
    a_speed_clear: assert property (p_speed_clear) else $error("speed done held"); // [R9]

    property p_speed_set;
        @(posedge CLK) disable iff (RESET)
        (state == DSSH_SPEED && !phase_rise && mode_req && at_speed && in_speed_tol)
        |=> SPEED_SYNC_DONE;
    endproperty
    a_speed_set: assert property (p_speed_set) else $error("speed done missing"); // [R8]

    property p_rise_drop;
        @(posedge CLK) disable iff (RESET)
        (phase_rise && state != DSSH_ALIGN) |=> !SPEED_SYNC_DONE;
    endproperty
    a_rise_drop: assert property (p_rise_drop) else $error("speed done kept on rise"); // [R14]

    property p_phase_clear;
        @(posedge CLK) disable iff (RESET)
        (state != DSSH_PHASED || !in_phase_tol) |=> !PHASE_SYNC_DONE;
    endproperty
    a_phase_clear: assert property (p_phase_clear) else $error("phase done held"); // [R11]

    property p_align_drop;
        @(posedge CLK) disable iff (RESET)
        state == DSSH_ALIGN |=> !SPEED_SYNC_DONE;
    endproperty
    a_align_drop: assert property (p_align_drop) else $error("speed done in align"); // [R14]

    property p_alarm;
        @(posedge CLK) disable iff (RESET)
        (!mode_req || !over_alarm) |=> !SYNC_ERROR_ALARM;
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm wrongly set"); // [R13]

    property p_alarm_set;
        @(posedge CLK) disable iff (RESET)
        (mode_req && sync_effective && over_alarm) |=> SYNC_ERROR_ALARM;
    endproperty
    a_alarm_set: assert property (p_alarm_set) else $error("alarm missing"); // [R12]
endmodule

// ===== src/dssh_regs.svh
// Constants for the dual spindle sync handshake
`ifndef DSSH_REGS_SVH
`define DSSH_REGS_SVH
`define DSSH_SPEED_W      16
`define DSSH_ERR_W        16
`define DSSH_PHASE_TIME_US 100
`define DSSH_CLK_MHZ      10
`define DSSH_PHASE_CYC    ((`DSSH_PHASE_TIME_US * `DSSH_CLK_MHZ) > 0 ? \
                           (`DSSH_PHASE_TIME_US * `DSSH_CLK_MHZ) : 1)
`define DSSH_SPD_TOL_RST  16'h0010
`define DSSH_PH_TOL_RST   16'h0008
`define DSSH_ALM_RST      16'h0100
`endif

// ===== src/dssh_pkg.sv
// Types for the dual spindle sync handshake
package dssh_pkg;
    typedef enum logic [1:0] {
        DSSH_OFF     = 2'b00,
        DSSH_SPEED   = 2'b01,
        DSSH_ALIGN   = 2'b10,
        DSSH_PHASED  = 2'b11
    } dssh_state_t;
endpackage

// ===== src/dssh_sync_if.sv
// Synchronised sequencer request bits passed to the core
`timescale 1ns/10ps
interface dssh_sync_if;
    logic [4:0] raw;
    logic [4:0] q;
    modport sync (input raw, output q);
    modport core (input q);
endinterface

// ===== src/dssh_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module dssh_pin_sync #(
    parameter int W = 5
) (
    input  wire logic clk,
    input  wire logic reset,
    dssh_sync_if.sync bus
);
    logic [W-1:0] s1, s2, s3, q;
    logic [W-1:0] next_q;
    // The carrier interface is fixed at five request bits
    if (W != 5) begin : g_bad_width
        $error("dssh_pin_sync: W must match the five-bit carrier");
    end
    // Output follows only once stages two and three agree
    always_comb begin
        for (int i = 0; i < W; i++) begin
            next_q[i] = (s2[i] == s3[i]) ? s3[i] : q[i];
        end
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            q  <= '0;
        end else begin
            s1 <= bus.raw;
            s2 <= s1;
            s3 <= s2;
            q  <= next_q;
        end
    end
    assign bus.q = q;
endmodule

// ===== dv/dssh_seq_model.sv
// Sequencer model driving the spindle sync request pins
`timescale 1ns/10ps
module dssh_seq_model (
    // Clock
    input  wire logic clk,
    // Bench intent
    input  wire logic want_mode,
    input  wire logic want_phase,
    input  wire logic coupled,
    input  wire logic want_fwd,
    input  wire logic rude,
    // Device status
    input  wire logic speed_done,
    // Request pins
    output logic      mode_pin,
    output logic      phase_pin,
    output logic      int_dis_first,
    output logic      int_dis_second,
    output logic      fwd_pin
);
    always @(posedge clk) begin
        mode_pin       <= #10 want_mode;
        // Rise only after speed sync is reported, unless told to misbehave
        phase_pin      <= #10 want_phase & (phase_pin | speed_done | rude);
        int_dis_first  <= #10 coupled;
        int_dis_second <= #10 coupled;
        // Direction frozen while in sync mode, unless told to misbehave
        fwd_pin        <= #10 (mode_pin & ~rude) ? fwd_pin : want_fwd;
    end
endmodule

// ===== dv/dssh_tb_top.sv
// Self-checking bench for the dual spindle sync handshake
`timescale 1ns/10ps
module dssh_tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        want_mode = 1'b0;
    logic        want_phase = 1'b0;
    logic        coupled = 1'b0;
    logic        rude = 1'b0;
    logic        want_fwd = 1'b1;
    logic [15:0] spd_first = 16'h0400;
    logic [15:0] spd_second = 16'h0408;
    logic [15:0] err = 16'h0000;
    logic        mode_pin, phase_pin, idf, ids, fwd, fwd_l, ien1, ien2;
    logic [3:0]  outs;
    int          mismatches = 0;
    int          cmp_count = 0;
    int          cycles = 0;

    always #50 clk = ~clk;

    dssh_seq_model u_seq (
        .clk(clk), .want_mode(want_mode), .want_phase(want_phase), .coupled(coupled),
        .want_fwd(want_fwd), .rude(rude), .speed_done(outs[0]), .mode_pin(mode_pin),
        .phase_pin(phase_pin), .int_dis_first(idf), .int_dis_second(ids), .fwd_pin(fwd)
    );

    dssh_core #(.PHASE_CYC(4)) u_dut (
        .CLK(clk), .RESET(rst), .SYNC_MODE_REQUEST(mode_pin),
        .PHASE_SYNC_REQUEST(phase_pin), .INTEGRAL_DISABLE_FIRST(idf),
        .INTEGRAL_DISABLE_SECOND(ids), .FORWARD_ROTATE_CMD(fwd),
        .SPEED_CMD(16'h0400), .SPEED_FIRST(spd_first), .SPEED_SECOND(spd_second),
        .ERR_PULSE_DIFF(err), .SPEED_TOL(16'h0010), .PHASE_TOL(16'h0008),
        .ALARM_THRESH(16'h0100), .SPEED_SYNC_DONE(outs[0]), .PHASE_SYNC_DONE(outs[1]),
        .SYNC_ERROR_ALARM(outs[2]), .INTEGRAL_EN_FIRST(ien1), .INTEGRAL_EN_SECOND(ien2),
        .ALIGN_ACTIVE(outs[3]), .FORWARD_LATCHED(fwd_l)
    );

    task automatic conclude();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask

    // Bounded wait on one status bit, then compare it
    task automatic await(input int idx, input logic v, input int lim, input string what);
        int n;
        n = 0;
        while (outs[idx] !== v && n < lim) begin
            idle(1);
            n++;
        end
        chk(what, v, outs[idx]);
    endtask

    // Hang guard well above the expected run length
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            mismatches++;
            conclude();
        end
    end

    initial begin
        idle(5);
        rst = 1'b0;
        chk("speed_done", 1'b0, outs[0]);
        chk("phase_done", 1'b0, outs[1]);
        chk("alarm", 1'b0, outs[2]);
        chk("int_en", 1'b1, ien1 & ien2);
        rude = 1'b1;
        want_phase = 1'b1;
        idle(12);
        chk("align_no_mode", 1'b0, outs[3]);
        chk("phase_no_mode", 1'b0, outs[1]);
        chk("fwd_latched", 1'b1, fwd_l);
        rude = 1'b0;
        want_phase = 1'b0;
        idle(8);
        want_mode = 1'b1;
        await(0, 1'b1, 12, "speed_done_on");
        spd_second = 16'h0411;
        await(0, 1'b0, 4, "speed_done_tol");
        spd_second = 16'h0408;
        await(0, 1'b1, 4, "speed_done_back");
        spd_first = 16'h0420;
        spd_second = 16'h0420;
        await(0, 1'b0, 4, "speed_done_cmd");
        spd_first = 16'h0400;
        spd_second = 16'h0408;
        await(0, 1'b1, 4, "speed_done_cmd_back");
        want_phase = 1'b1;
        await(3, 1'b1, 10, "align_start");
        chk("speed_drop", 1'b0, outs[0]);
        await(1, 1'b1, 12, "phase_done_on");
        chk("speed_again", 1'b1, outs[0]);
        err = 16'h0009;
        await(1, 1'b0, 4, "phase_done_tol");
        chk("alarm_low", 1'b0, outs[2]);
        err = 16'h0101;
        await(2, 1'b1, 4, "alarm_on");
        err = 16'h0100;
        await(2, 1'b0, 4, "alarm_edge");
        err = 16'h0008;
        await(1, 1'b1, 4, "phase_done_edge");
        want_phase = 1'b0;
        idle(10);
        chk("phase_kept", 1'b1, outs[1]);
        chk("no_realign", 1'b0, outs[3]);
        want_phase = 1'b1;
        await(3, 1'b1, 10, "realign");
        await(1, 1'b1, 12, "realign_done");
        coupled = 1'b1;
        rude = 1'b1;
        want_fwd = 1'b0;
        idle(8);
        chk("int_first", 1'b0, ien1);
        chk("int_second", 1'b0, ien2);
        chk("fwd_held", 1'b1, fwd_l);
        coupled = 1'b0;
        want_fwd = 1'b1;
        want_phase = 1'b0;
        err = 16'h0101;
        idle(8);
        rude = 1'b0;
        chk("int_back", 1'b1, ien1 & ien2);
        chk("alarm_hi", 1'b1, outs[2]);
        want_mode = 1'b0;
        want_fwd = 1'b0;
        await(0, 1'b0, 10, "speed_done_off");
        await(1, 1'b0, 2, "phase_off");
        await(2, 1'b0, 2, "alarm_off");
        idle(4);
        chk("fwd_free", 1'b0, fwd_l);
        conclude();
    end
endmodule
